// >>> pc_seq_consts.vh
`ifndef PC_SEQ_CONSTS_VH
`define PC_SEQ_CONSTS_VH

// Register offsets on the plain register port
`define OFS_PC_LOW_BYTE      4'h0
`define OFS_PC_SNAPSHOT_LOW  4'h1
`define OFS_PC_SNAPSHOT_HIGH 4'h2
`define OFS_SEQ_CONTROL      4'h3
`define OFS_SEQ_STATUS       4'h4

// Control register field positions
`define CTRL_BANK_BIT        0
`define CTRL_SLOW_OSC_BIT    1

// Reset values
`define RST_PC_LOW13         13'h0000
`define RST_BANK             1'b0
`define RST_BYTE             8'h00
`define RST_WORD             16'h0000
`define RST_ADDR14           14'h0000
`define RST_HOLD6            6'h00

// Phase indices inside one instruction cycle
`define PH_T1                0
`define PH_T2                1
`define PH_T3                2
`define PH_T4                3
`define PHASE_RESET          4'h1

// Slow oscillator stand-in: one phase tick every SLOW_DIV system clocks
`define SLOW_DIV             8'h08
`define FAST_DIV             8'h01

`endif

// >>> pc_seq_properties.sv
`default_nettype none
// Port-level watcher for the sequencer; sees only top-level pins
module pc_seq_checker (
  input wire logic        i_sys_clk,       // System clock
  input wire logic        i_reset,         // Sync reset, active high
  input wire logic [3:0]  i_addr,          // Register address
  input wire logic        i_rd,            // Register read strobe
  input wire logic [7:0]  o_rdata,         // Register read data
  input wire logic [13:0] o_fetch_addr,    // Fetch address
  input wire logic        o_fetch_strobe,  // Fetch pulse
  input wire logic [13:0] o_exec_addr,     // Executing address
  input wire logic        o_irq_ack,       // Interrupt taken pulse
  input wire logic [3:0]  o_phase          // One-hot phase
);
  logic [5:0] hold_ff;  // Own copy of the snapshot high buffer

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  // Shadow buffer, loaded only by a snapshot low read
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      hold_ff <= 6'h00;
    else if (i_rd && (i_addr == 4'h1))
      hold_ff <= o_exec_addr[13:8];
  end

  AST_PHASE_ONEHOT: assert property ($onehot(o_phase))
    else $error("phase not one-hot");
  AST_PHASE_ROTATE: assert property ($changed(o_phase) |->
    o_phase == {$past(o_phase[2:0]), $past(o_phase[3])})
    else $error("phase skipped or reversed");
  AST_STROBE_PULSE: assert property (o_fetch_strobe |=> !o_fetch_strobe)
    else $error("fetch strobe longer than one cycle");
  AST_FETCH_WITH_STROBE: assert property ($changed(o_fetch_addr) |-> o_fetch_strobe)
    else $error("fetch address moved without strobe");
  AST_EXEC_AT_T1: assert property ($changed(o_exec_addr) |-> o_fetch_strobe)
    else $error("exec address moved outside T1");
  AST_SNAP_LOW: assert property ($past(i_rd) && ($past(i_addr) == 4'h1) |->
    o_rdata == $past(o_exec_addr[7:0]))
    else $error("snapshot low wrong");
  AST_SNAP_HIGH: assert property ($past(i_rd) && ($past(i_addr) == 4'h2) |->
    o_rdata == {2'b00, hold_ff})
    else $error("snapshot high wrong");
  AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside read slot");
  AST_IRQ_ACK_PULSE: assert property (o_irq_ack |=> !o_irq_ack)
    else $error("interrupt ack longer than one cycle");

  COV_IRQ: cover property (o_irq_ack);
  COV_SNAP: cover property (i_rd && (i_addr == 4'h1) ##1 i_rd && (i_addr == 4'h2));
  COV_SLOW: cover property (o_phase[0] [*8]);
endmodule

bind program_counter_sequencer pc_seq_checker u_checker (
  .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_addr(i_addr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_fetch_addr(o_fetch_addr), .o_fetch_strobe(o_fetch_strobe),
  .o_exec_addr(o_exec_addr), .o_irq_ack(o_irq_ack), .o_phase(o_phase));
`default_nettype wire

// >>> phase_generator.v
`default_nettype none

// Splits the selected oscillator rate into four non-overlapping phases.
module phase_generator (
  input  wire       i_sys_clk,      // System clock
  input  wire       i_reset,        // Synchronous reset, active high
  input  wire       i_slow_select,  // High selects the slow oscillator rate
  output wire [3:0] o_phase,        // One-hot phase level
  output wire [3:0] o_phase_en      // One-cycle pulse on entry of each phase
);
`include "pc_seq_consts.vh"

  reg  [7:0] div_cnt_ff;    // Tick divider
  reg  [7:0] nxt_div_cnt;
  reg  [7:0] div_lim_ff;    // Divider limit, changed only at cycle wrap
  reg  [3:0] phase_ff;      // One-hot phase
  reg        entry_ff;      // Pulse marks phase entry
  wire       tick;          // Phase advance enable
  wire [7:0] sel_lim;       // Limit asked for by the select input

  assign sel_lim = i_slow_select ? `SLOW_DIV : `FAST_DIV;
  assign tick    = (div_cnt_ff == div_lim_ff - 8'h01);

  // Divider count for the oscillator rate
  always @*
  begin
    nxt_div_cnt = tick ? 8'h00 : div_cnt_ff + 8'h01;
  end

  // Phase rotation; rate switch waits for the T4 to T1 wrap so no phase is cut short
  always @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      div_cnt_ff <= 8'h00;
      div_lim_ff <= `FAST_DIV;
      phase_ff   <= `PHASE_RESET;
      entry_ff   <= 1'b1;
    end
    else
    begin
      div_cnt_ff <= nxt_div_cnt;
      entry_ff   <= tick;
      if (tick)
      begin
        phase_ff <= {phase_ff[2:0], phase_ff[3]}; // (RULE1)
        if (phase_ff[`PH_T4])
        begin
          div_lim_ff <= sel_lim; // (RULE14)
          div_cnt_ff <= 8'h00;
        end
      end
    end
  end

  assign o_phase    = phase_ff;
  assign o_phase_en = entry_ff ? phase_ff : 4'h0;

endmodule

`default_nettype wire

// >>> prog_mem_model.sv
`default_nettype none
// Program memory stand-in, read continuously like a ROM
module prog_mem_model (
  input  wire logic [13:0] i_fetch_addr,  // Address from sequencer
  output logic      [15:0] o_fetch_data   // Word at that address
);
  timeunit 1ns;
  timeprecision 1ps;
  // Unique word per address so a wrong fetch cannot hide
  assign o_fetch_data = {i_fetch_addr, 2'b01};
endmodule
`default_nettype wire

// >>> program_counter_sequencer.v
// Added by the designer: strobed register access and the register offsets.
`default_nettype none

// Summary of operation
// (RULE1) Four non-overlapping phases form one cycle
// (RULE2) Increment counter at T1, fetch during T1
// (RULE3) Fetch next while current one executes
// (RULE4) Standard one cycle, extended two cycles
// (RULE5) Jump or call costs two cycles
// (RULE6) Counter advances by one per instruction
// (RULE7) Upper address is bank bit plus bits 12-8
// (RULE8) Only low counter byte is register-visible
// (RULE9) Jumps, calls, interrupts, reset load the counter
// (RULE10) Taken skip discards prefetch, runs dummy cycle
// (RULE11) Low byte write jumps in page, dummy
// (RULE12) Snapshot low read latches high byte
// (RULE13) Software reads snapshot low before high
// (RULE14) Phase clock from fast or slow oscillator
// (RULE15) Snapshot high shows bits 13-8, top zero
// (RULE16) Snapshot buffer holds until next low read
module program_counter_sequencer (
  input  wire        i_sys_clk,        // System clock, 40 MHz
  input  wire        i_reset,          // Synchronous reset, active high
  input  wire [15:0] i_fetch_data,     // Program memory word for o_fetch_addr
  input  wire        i_branch_req,     // Decoder: jump or call taken, sampled at T4
  input  wire [12:0] i_branch_target,  // Decoder: branch target within bank
  input  wire        i_skip_taken,     // Decoder: skip condition met, sampled at T4
  input  wire        i_extended,       // Decoder: current word opens an extended one
  input  wire        i_irq_req,        // Interrupt request level
  input  wire [12:0] i_irq_vector,     // Interrupt entry address
  input  wire [3:0]  i_addr,           // Register address
  input  wire [7:0]  i_wdata,          // Register write data
  input  wire        i_wr,             // Register write strobe
  input  wire        i_rd,             // Register read strobe
  output wire [7:0]  o_rdata,          // Register read data, cycle after i_rd
  output wire [13:0] o_fetch_addr,     // Program memory address
  output wire        o_fetch_strobe,   // One-cycle pulse in the clock after T1 entry
  output wire [15:0] o_instr,          // Word under execution
  output wire        o_instr_valid,    // Low in a dummy cycle
  output wire        o_operand_cycle,  // Second cycle of an extended word
  output wire [13:0] o_exec_addr,      // Address of the word under execution
  output wire        o_irq_ack,        // One-cycle pulse when an interrupt is taken
  output wire [3:0]  o_phase           // One-hot phase, T1 in bit 0
);
`include "pc_seq_consts.vh"

  // Address hit test shared by the write and read decoders
  function hit;
    input [3:0] addr;
    input [3:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  wire [3:0]  phase;              // Phase level
  wire [3:0]  phase_en;           // Phase entry pulses
  wire        t1_go;              // Entry of T1
  wire        t2_go;              // Entry of T2
  wire        t4_go;              // Entry of T4

  reg  [12:0] pc_ff;              // Next fetch address within the bank
  reg  [12:0] nxt_pc;
  reg         pc_bank_ff;         // Bank bit applied to fetches
  reg         nxt_pc_bank;
  reg  [13:0] fetch_addr_ff;      // Address presented to program memory
  reg         fetch_strobe_ff;    // Fetch pulse
  reg  [15:0] fetched_ff;         // Word caught at T2 entry
  reg  [15:0] instr_ff;           // Word under execution
  reg         instr_valid_ff;     // Executing word is real
  reg         operand_ff;         // Executing word is an operand word
  reg  [13:0] exec_addr_ff;       // Address of the executing word
  reg         discard_ff;         // Drop the word fetched this cycle
  reg         nxt_discard;
  reg         ext_pend_ff;        // Next word is an operand word
  reg         nxt_ext_pend;
  reg         irq_ack_ff;         // Interrupt taken pulse
  reg         nxt_irq_ack;
  reg         pcl_pend_ff;        // Software low-byte write waiting for T4
  reg  [7:0]  pcl_data_ff;        // Value of that write
  reg         bank_sel_ff;        // Software bank select bit
  reg         slow_osc_ff;        // Software oscillator select
  reg  [5:0]  hold_ff;            // Snapshot high holding buffer
  reg  [7:0]  rdata_ff;           // Read data
  reg  [7:0]  nxt_rdata;
  reg         last_dummy_ff;      // A dummy cycle has run since last status read

  wire        wr_pcl;             // Write to the low byte
  wire        wr_ctrl;            // Write to the control register
  wire        rd_snap_lo;         // Read of the snapshot low register
  wire        can_act;            // Executing word may steer the counter
  wire        pcl_take;           // Low-byte write consumed at this T4; a branch at the same T4 wins

  assign t1_go = phase_en[`PH_T1];
  assign t2_go = phase_en[`PH_T2];
  assign t4_go = phase_en[`PH_T4];

  // Phase source; the rate follows the oscillator select bit
  phase_generator u_phase (
    .i_sys_clk     (i_sys_clk),
    .i_reset       (i_reset),
    .i_slow_select (slow_osc_ff),
    .o_phase       (phase),
    .o_phase_en    (phase_en)
  );

  // Register strobes decoded once
  assign wr_pcl     = i_wr & hit(i_addr, `OFS_PC_LOW_BYTE);
  assign wr_ctrl    = i_wr & hit(i_addr, `OFS_SEQ_CONTROL);
  assign rd_snap_lo = i_rd & hit(i_addr, `OFS_PC_SNAPSHOT_LOW);

  // Dummy cycles and the operand word of an extended pair never act on decoder requests; a pending low-byte write still redirects the counter
  assign can_act  = instr_valid_ff & ~operand_ff;
  assign pcl_take = t4_go & pcl_pend_ff;

  // Counter steering decided at T4, applied to the fetch that starts at T1
  always @*
  begin
    nxt_pc       = pc_ff;
    nxt_pc_bank  = pc_bank_ff;
    nxt_discard  = discard_ff;
    nxt_ext_pend = ext_pend_ff;
    nxt_irq_ack  = 1'b0;
    if (t1_go)
    begin
      nxt_pc      = pc_ff + 13'h0001; // (RULE2) (RULE6)
      nxt_discard = 1'b0;
    end
    else if (t4_go)
    begin
      nxt_ext_pend = 1'b0;
      if (can_act & i_branch_req)
      begin
        // Jump or call: target loaded, prefetched word dropped
        nxt_pc      = i_branch_target; // (RULE9)
        nxt_pc_bank = bank_sel_ff; // (RULE7)
        nxt_discard = 1'b1; // (RULE5)
      end
      else if (pcl_take)
      begin
        // Low-byte write keeps the page of the executing word
        nxt_pc      = {exec_addr_ff[12:8], pcl_data_ff}; // (RULE11)
        nxt_discard = 1'b1; // (RULE11)
      end
      else if (can_act & i_skip_taken)
      begin
        // Counter already moved past the skipped word
        nxt_discard = 1'b1; // (RULE10)
      end
      else if (can_act & i_extended)
      begin
        // Prefetched word is the operand, so the pair takes two cycles
        nxt_ext_pend = 1'b1; // (RULE4)
      end
      else if (can_act & i_irq_req)
      begin
        // Interrupts enter in bank zero and drop the prefetch like a call
        nxt_pc      = i_irq_vector; // (RULE9)
        nxt_pc_bank = `RST_BANK;
        nxt_discard = 1'b1;
        nxt_irq_ack = 1'b1;
      end
    end
  end

  // Counter, fetch and execute pipeline
  always @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      pc_ff           <= `RST_PC_LOW13; // (RULE9)
      pc_bank_ff      <= `RST_BANK;
      fetch_addr_ff   <= `RST_ADDR14;
      fetch_strobe_ff <= 1'b0;
      fetched_ff      <= `RST_WORD;
      instr_ff        <= `RST_WORD;
      instr_valid_ff  <= 1'b0;
      operand_ff      <= 1'b0;
      exec_addr_ff    <= `RST_ADDR14;
      discard_ff      <= 1'b1;
      ext_pend_ff     <= 1'b0;
      irq_ack_ff      <= 1'b0;
    end
    else
    begin
      pc_ff           <= nxt_pc;
      pc_bank_ff      <= nxt_pc_bank;
      discard_ff      <= nxt_discard;
      ext_pend_ff     <= nxt_ext_pend;
      irq_ack_ff      <= nxt_irq_ack;
      fetch_strobe_ff <= t1_go;
      if (t1_go)
      begin
        // New fetch starts while the last fetched word moves to execute
        fetch_addr_ff  <= {pc_bank_ff, pc_ff}; // (RULE7)
        instr_ff       <= fetched_ff; // (RULE3)
        exec_addr_ff   <= fetch_addr_ff;
        instr_valid_ff <= ~discard_ff; // (RULE10)
        operand_ff     <= ext_pend_ff & ~discard_ff; // (RULE4)
      end
      if (t2_go)
      begin
        // Memory has had from one clock after T1 entry to the first clock of T2 to answer
        fetched_ff <= i_fetch_data; // (RULE2)
      end
    end
  end

  // Software-facing state: low-byte write, control, snapshot buffer
  always @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      pcl_pend_ff   <= 1'b0;
      pcl_data_ff   <= `RST_BYTE;
      bank_sel_ff   <= `RST_BANK;
      slow_osc_ff   <= 1'b0;
      hold_ff       <= `RST_HOLD6; // (RULE16)
      last_dummy_ff <= 1'b0;
    end
    else
    begin
      // A new write in the consuming cycle stays pending
      pcl_pend_ff <= wr_pcl | (pcl_pend_ff & ~pcl_take); // (RULE11)
      if (wr_pcl)
      begin
        pcl_data_ff <= i_wdata;
      end
      if (wr_ctrl)
      begin
        bank_sel_ff <= i_wdata[`CTRL_BANK_BIT]; // (RULE7)
        slow_osc_ff <= i_wdata[`CTRL_SLOW_OSC_BIT]; // (RULE14)
      end
      if (rd_snap_lo)
      begin
        // Only a low read refreshes the buffer, so a high read sees a matched pair
        hold_ff <= exec_addr_ff[13:8]; // (RULE12)
      end
      // Dummy flag: a new dummy cycle wins over the clearing status read
      if (t1_go & discard_ff)
      begin
        last_dummy_ff <= 1'b1;
      end
      else if (i_rd & hit(i_addr, `OFS_SEQ_STATUS))
      begin
        last_dummy_ff <= 1'b0;
      end
    end
  end

  // Read multiplexer; the upper counter bits have no address of their own
  always @*
  begin
    nxt_rdata = `RST_BYTE;
    if (hit(i_addr, `OFS_PC_LOW_BYTE))
    begin
      nxt_rdata = pc_ff[7:0]; // (RULE8)
    end
    else if (hit(i_addr, `OFS_PC_SNAPSHOT_LOW))
    begin
      nxt_rdata = exec_addr_ff[7:0]; // (RULE12)
    end
    else if (hit(i_addr, `OFS_PC_SNAPSHOT_HIGH))
    begin
      // Value pairs with the preceding low read
      nxt_rdata = {2'b00, hold_ff}; // (RULE15) (RULE13)
    end
    else if (hit(i_addr, `OFS_SEQ_CONTROL))
    begin
      nxt_rdata = {6'h00, slow_osc_ff, bank_sel_ff};
    end
    else if (hit(i_addr, `OFS_SEQ_STATUS))
    begin
      nxt_rdata = {last_dummy_ff, operand_ff, instr_valid_ff, pcl_pend_ff, phase};
    end
  end

  // Read data stands for the single cycle after the strobe
  always @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      rdata_ff <= `RST_BYTE;
    end
    else if (i_rd)
    begin
      rdata_ff <= nxt_rdata;
    end
    else
    begin
      rdata_ff <= `RST_BYTE;
    end
  end

  assign o_rdata         = rdata_ff;
  assign o_fetch_addr    = fetch_addr_ff;
  assign o_fetch_strobe  = fetch_strobe_ff;
  assign o_instr         = instr_ff;
  assign o_instr_valid   = instr_valid_ff;
  assign o_operand_cycle = operand_ff;
  assign o_exec_addr     = exec_addr_ff;
  assign o_irq_ack       = irq_ack_ff;
  assign o_phase         = phase;

endmodule

`default_nettype wire

// >>> testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_sys_clk = 1'b0;                        // 40 MHz clock
  logic        i_reset = 1'b1;                          // Sync reset
  logic        i_branch_req = 1'b0, i_skip_taken = 1'b0;  // Decoder flags
  logic        i_extended = 1'b0, i_irq_req = 1'b0;     // Decoder flags
  logic [12:0] i_branch_target = 13'h0000, i_irq_vector = 13'h0000;
  logic [3:0]  i_addr = 4'h0;                           // Register address
  logic [7:0]  i_wdata = 8'h00;                         // Write data
  logic        i_wr = 1'b0, i_rd = 1'b0;                // Strobes
  wire  [15:0] i_fetch_data, o_instr;                   // Memory word, executing word
  wire  [13:0] o_fetch_addr, o_exec_addr;               // Addresses
  wire  [7:0]  o_rdata;                                 // Read data
  wire  [3:0]  o_phase;                                 // Phase
  wire         o_fetch_strobe, o_instr_valid, o_operand_cycle, o_irq_ack;
  int          failures = 0, tests_run = 0, cycles = 0, n;
  logic [13:0] fa, ea, fa0;                             // Sampled at the fetch pulse
  logic [12:0] tgt;                                     // Random target
  logic [7:0]  rd, v;                                   // Read value, write value
  logic        vld, bank, ack;                          // Sampled flags

  program_counter_sequencer u_dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .i_fetch_data(i_fetch_data), .i_branch_req(i_branch_req),
    .i_branch_target(i_branch_target), .i_skip_taken(i_skip_taken), .i_extended(i_extended),
    .i_irq_req(i_irq_req), .i_irq_vector(i_irq_vector), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_fetch_addr(o_fetch_addr),
    .o_fetch_strobe(o_fetch_strobe), .o_instr(o_instr), .o_instr_valid(o_instr_valid),
    .o_operand_cycle(o_operand_cycle), .o_exec_addr(o_exec_addr), .o_irq_ack(o_irq_ack),
    .o_phase(o_phase));
  prog_mem_model u_mem (.i_fetch_addr(o_fetch_addr), .o_fetch_data(i_fetch_data));

  // Free-running clock
  always #12.5 i_sys_clk = ~i_sys_clk;

  // Expected memory word, same pattern as the memory stand-in
  function automatic logic [15:0] word(input logic [13:0] a);
    return {a, 2'b01};
  endfunction

  task automatic test_done();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Hang guard: a full run needs a few hundred cycles
  always @(posedge i_sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      test_done();
    end
  end

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d, output logic [13:0] e);
    @(posedge i_sys_clk);
    i_rd <= 1'b1; i_addr <= a;
    #1 e = o_exec_addr;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  // Waits for the next fetch pulse, counting cycles, bounded
  task automatic next_fetch(output int gap);
    gap = 0;
    do begin @(posedge i_sys_clk); #1 gap++; end while (!o_fetch_strobe && gap < 100);
    fa = o_fetch_addr; vld = o_instr_valid; ea = o_exec_addr;
  endtask

  // From a fetch pulse cycle, holds decoder flags across exactly one T4 entry
  task automatic decode(input logic br, input logic sk, input logic ex, input logic irq);
    ack = 1'b0;
    i_branch_req <= br; i_skip_taken <= sk; i_extended <= ex; i_irq_req <= irq;
    i_branch_target <= tgt; i_irq_vector <= tgt;
    repeat (4) begin @(posedge i_sys_clk); #1 ack |= o_irq_ack; end
    i_branch_req <= 1'b0; i_skip_taken <= 1'b0; i_extended <= 1'b0; i_irq_req <= 1'b0;
    fa = o_fetch_addr; vld = o_instr_valid; ea = o_exec_addr;
  endtask

  initial
  begin
    void'($urandom(49296));
    repeat (3) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    reg_rd(4'h2, rd, ea); check("snap_high_reset", rd, 8'h00);
    v = 8'h05 + 8'($urandom_range(0, 10));
    reg_wr(v[3:0], 8'($urandom)); reg_rd(v[3:0], rd, ea); check("unmapped", rd, 8'h00);
    next_fetch(n);
    repeat (4)
    begin
      fa0 = fa; next_fetch(n);
      check("fetch_step", fa, fa0 + 14'h0001);
      check("phase_count", n, 4);
      check("exec_overlap", ea, fa0);
      check("word", o_instr, word(fa0));
    end
    // Jumps into random banks, snapshot read after each
    repeat (5)
    begin
      bank = 1'($urandom); reg_wr(4'h3, {7'h00, bank});
      next_fetch(n); tgt = 13'($urandom);
      decode(1'b1, 1'b0, 1'b0, 1'b0);
      check("jump_addr", fa, {bank, tgt});
      check("jump_dummy", vld, 1'b0);
      next_fetch(n);
      check("jump_exec", ea, {bank, tgt});
      check("jump_word", o_instr, word({bank, tgt}));
      reg_rd(4'h1, rd, ea); check("snap_low", rd, ea[7:0]);
      reg_rd(4'h2, rd, fa0); check("snap_high", rd, {2'b00, ea[13:8]});
    end
    next_fetch(n); fa0 = fa;
    decode(1'b0, 1'b1, 1'b0, 1'b0);
    check("skip_addr", fa, fa0 + 14'h0001);
    check("skip_dummy", vld, 1'b0);
    next_fetch(n); check("skip_exec", ea, fa0 + 14'h0001);
    next_fetch(n); fa0 = fa;
    decode(1'b0, 1'b0, 1'b1, 1'b0);
    check("ext_operand", o_operand_cycle, 1'b1);
    check("ext_exec", ea, fa0);
    next_fetch(n); check("ext_done", o_operand_cycle, 1'b0);
    next_fetch(n); tgt = 13'($urandom);
    decode(1'b0, 1'b0, 1'b0, 1'b1);
    check("irq_ack", ack, 1'b1);
    check("irq_addr", fa, {1'b0, tgt});
    check("irq_dummy", vld, 1'b0);
    next_fetch(n); fa0 = fa;
    reg_rd(4'h0, rd, ea); check("pcl_read", rd, fa0[7:0] + 8'h01);
    next_fetch(n); fa0 = fa; v = 8'($urandom); tgt = ea[12:0];
    reg_wr(4'h0, v);
    next_fetch(n);
    check("pcl_jump", fa, {fa0[13], tgt[12:8], v});
    check("pcl_dummy", vld, 1'b0);
    reg_rd(4'h4, rd, ea); check("dummy_seen", rd[7], 1'b1);
    reg_rd(4'h4, rd, ea); check("dummy_clear", rd[7], 1'b0);
    // Slow oscillator: eight clocks per phase
    reg_wr(4'h3, 8'h02);
    next_fetch(n); next_fetch(n); next_fetch(n);
    check("slow_gap", n, 32);
    reg_wr(4'h3, 8'h00);
    next_fetch(n); next_fetch(n); next_fetch(n);
    check("fast_gap", n, 4);
    test_done();
  end
endmodule
`default_nettype wire

// >>> unused_placeholder_none.v
`default_nettype none
`default_nettype wire
